/* File: design/fra_core.sv */
// Operation
// - Rotate right puts the flag into bit 7, bit 0 into the flag.
// - Destination select 0 writes the accumulator, 1 writes the file register.
// - Subtract-from-file computes file minus accumulator, two's complement.
// - It updates borrow-inverse, nibble flag and zero flag by unsigned compares.
// - Subtract-from-literal gives literal minus accumulator into accumulator, same flags.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep sets the timeout flag and clears the power-down flag.
// - After sleep the oscillator halts and no instruction executes.
// - Nibble exchange swaps the halves, writes destination, flags untouched.
// - Xor literal into accumulator, only the zero flag changes.
// - Xor accumulator with file to destination, only the zero flag changes.
`timescale 1ns/1ps
`default_nettype none
module fra_core
  import fra_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       op_valid,
  input  wire fra_op_t    op_code,
  input  wire logic [6:0] file_addr,
  input  wire logic       dest_sel,
  input  wire logic [7:0] literal,
  input  wire logic [7:0] file_rdata,
  input  wire logic       wake,
  input  wire logic       watchdog_tick,
  output logic      [7:0] acc_q,
  output logic            file_we_q,
  output logic      [6:0] file_waddr_q,
  output logic      [7:0] file_wdata_q,
  output logic            borrow_inverse_flag_q,
  output logic            nibble_borrow_inverse_flag_q,
  output logic            zero_flag_q,
  output logic            timeout_flag_q,
  output logic            power_down_flag_q,
  output logic      [7:0] watchdog_counter_q,
  output logic            osc_halt_q
);

  fra_alu_if alu_bus ();

  fra_alu u_alu (
    .bus (alu_bus)
  );

  // Wake and watchdog tick come from other clocks
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] async_in;

  assign async_in = {watchdog_tick, wake};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic wake_s;
  logic tick_s;
  logic tick_prev_q;
  logic tick_edge;

  assign wake_s    = sync2_q[0];
  assign tick_s    = sync2_q[1];
  assign tick_edge = tick_s & ~tick_prev_q;

  fra_state_t state_q;
  fra_state_t state_d;
  logic [7:0] acc_d;
  logic       file_we_d;
  logic [6:0] file_waddr_d;
  logic [7:0] file_wdata_d;
  logic       c_d;
  logic       dc_d;
  logic       z_d;
  logic       to_d;
  logic       pd_d;
  logic [7:0] wdt_d;
  logic [6:0] pre_q;
  logic [6:0] pre_d;
  logic       exec;
  logic       halt_d;

  assign alu_bus.op   = op_code;
  assign alu_bus.acc  = acc_q;
  assign alu_bus.fval = file_rdata;
  assign alu_bus.lit  = literal;
  assign alu_bus.cin  = borrow_inverse_flag_q;

  // Instructions are only taken while running
  assign exec = op_valid && (state_q == FRA_ST_RUN);

  always_comb begin
    state_d      = state_q;
    acc_d        = acc_q;
    file_we_d    = 1'b0;
    file_waddr_d = file_waddr_q;
    file_wdata_d = file_wdata_q;
    c_d          = borrow_inverse_flag_q;
    dc_d         = nibble_borrow_inverse_flag_q;
    z_d          = zero_flag_q;
    to_d         = timeout_flag_q;
    pd_d         = power_down_flag_q;
    pre_d        = pre_q;
    wdt_d        = watchdog_counter_q;
    // Watchdog keeps counting in sleep, it runs on its own oscillator
    if (tick_edge) begin
      pre_d = pre_q + FRA_PRE_ONE;
      if (pre_q == FRA_PRE_MAX) begin
        wdt_d = watchdog_counter_q + FRA_WDT_ONE;
      end
    end
    unique case (state_q)
      FRA_ST_RUN: begin
        if (exec) begin
          if (op_code == FRA_OP_SLEEP) begin
            wdt_d   = FRA_ZERO_BYTE;
            pre_d   = FRA_PRE_RST;
            to_d    = FRA_FLAG_SET;
            pd_d    = FRA_FLAG_CLR;
            state_d = FRA_ST_SLEEP;
          end else begin
            if (alu_bus.wr_c) begin
              c_d = alu_bus.cout;
            end
            if (alu_bus.wr_dc) begin
              dc_d = alu_bus.dcout;
            end
            if (alu_bus.wr_z) begin
              z_d = alu_bus.zout;
            end
            // Literal forms always land in the accumulator
            if (op_code == FRA_OP_SUB_ACC_FROM_LITERAL || op_code == FRA_OP_XOR_LITERAL_INTO_ACC ||
                dest_sel == FRA_DEST_ACC) begin
              acc_d = alu_bus.result;
            end else begin
              file_we_d    = alu_bus.wr_result;
              file_waddr_d = file_addr;
              file_wdata_d = alu_bus.result;
            end
          end
        end
      end
      FRA_ST_SLEEP: begin
        if (wake_s) begin
          state_d = FRA_ST_RUN;
        end
      end
    endcase
    // Halt follows the next state so it drops on the edge that resumes running
    halt_d = (state_d == FRA_ST_SLEEP);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q                      <= FRA_ST_RUN;
      acc_q                        <= FRA_ZERO_BYTE;
      file_we_q                    <= 1'b0;
      file_waddr_q                 <= FRA_ADDR_RST;
      file_wdata_q                 <= FRA_ZERO_BYTE;
      borrow_inverse_flag_q        <= FRA_FLAG_CLR;
      nibble_borrow_inverse_flag_q <= FRA_FLAG_CLR;
      zero_flag_q                  <= FRA_FLAG_CLR;
      timeout_flag_q               <= FRA_TO_RST;
      power_down_flag_q            <= FRA_PD_RST;
      watchdog_counter_q           <= FRA_ZERO_BYTE;
      pre_q                        <= FRA_PRE_RST;
      osc_halt_q                   <= 1'b0;
      tick_prev_q                  <= 1'b0;
    end else begin
      state_q                      <= state_d;
      acc_q                        <= acc_d;
      file_we_q                    <= file_we_d;
      file_waddr_q                 <= file_waddr_d;
      file_wdata_q                 <= file_wdata_d;
      borrow_inverse_flag_q        <= c_d;
      nibble_borrow_inverse_flag_q <= dc_d;
      zero_flag_q                  <= z_d;
      timeout_flag_q               <= to_d;
      power_down_flag_q            <= pd_d;
      watchdog_counter_q           <= wdt_d;
      pre_q                        <= pre_d;
      osc_halt_q                   <= halt_d;
      tick_prev_q                  <= tick_s;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic file_dest;
  assign file_dest = dest_sel == FRA_DEST_FILE && op_code != FRA_OP_SUB_ACC_FROM_LITERAL &&
                     op_code != FRA_OP_XOR_LITERAL_INTO_ACC && op_code != FRA_OP_SLEEP;

  chk_rotate_right: assert property (exec && op_code == FRA_OP_ROTATE_RIGHT_THRU_FLAG && !file_dest |=>
    acc_q == {$past(borrow_inverse_flag_q), $past(file_rdata[7:1])} && borrow_inverse_flag_q == $past(file_rdata[0]))
    else $error("rotate right result or flag wrong");

  chk_dest_file: assert property (exec && file_dest |=> file_we_q && file_waddr_q == $past(file_addr) &&
    $stable(acc_q))
    else $error("file destination not written");

  chk_dest_acc: assert property (exec && !file_dest && op_code != FRA_OP_SLEEP |=> !file_we_q)
    else $error("accumulator destination wrote the file");

  chk_sub_file: assert property (exec && op_code == FRA_OP_SUB_ACC_FROM_FILE && !file_dest |=>
    acc_q == 8'($past(file_rdata) - $past(acc_q)))
    else $error("subtract from file value wrong");

  chk_sub_flags: assert property (exec && op_code == FRA_OP_SUB_ACC_FROM_FILE |=>
    borrow_inverse_flag_q == ($past(acc_q) <= $past(file_rdata)) &&
    nibble_borrow_inverse_flag_q == ($past(acc_q[3:0]) <= $past(file_rdata[3:0])))
    else $error("subtract from file flags wrong");

  chk_sub_literal: assert property (exec && op_code == FRA_OP_SUB_ACC_FROM_LITERAL |=>
    acc_q == 8'($past(literal) - $past(acc_q)) && borrow_inverse_flag_q == ($past(acc_q) <= $past(literal)))
    else $error("subtract from literal wrong");

  chk_sleep_wdt: assert property (exec && op_code == FRA_OP_SLEEP |=> watchdog_counter_q == FRA_ZERO_BYTE &&
    pre_q == FRA_PRE_RST)
    else $error("sleep did not clear watchdog");

  chk_sleep_flags: assert property (exec && op_code == FRA_OP_SLEEP |=> timeout_flag_q && !power_down_flag_q)
    else $error("sleep status flags wrong");

  chk_sleep_halt: assert property (state_q == FRA_ST_SLEEP && op_valid |=> $stable(acc_q) && !file_we_q &&
    $stable(zero_flag_q))
    else $error("instruction executed while asleep");

  chk_swap_flags: assert property (exec && op_code == FRA_OP_NIBBLE_EXCHANGE |=>
    $stable(zero_flag_q) && $stable(borrow_inverse_flag_q) && $stable(nibble_borrow_inverse_flag_q))
    else $error("nibble exchange touched flags");

  chk_xor_lit: assert property (exec && op_code == FRA_OP_XOR_LITERAL_INTO_ACC |=>
    acc_q == ($past(acc_q) ^ $past(literal)) && $stable(borrow_inverse_flag_q))
    else $error("xor literal wrong");

  chk_xor_file: assert property (exec && op_code == FRA_OP_XOR_ACC_WITH_FILE && file_dest |=>
    file_wdata_q == ($past(acc_q) ^ $past(file_rdata)) && $stable(nibble_borrow_inverse_flag_q))
    else $error("xor file wrong");

  chk_zero_flag: assert property (exec && op_code == FRA_OP_XOR_LITERAL_INTO_ACC |=>
    zero_flag_q == (acc_q == FRA_ZERO_BYTE))
    else $error("zero flag mismatch");

  // Expectations built from operands, not from the datapath result
  chk_rotate_file: assert property (exec && op_code == FRA_OP_ROTATE_RIGHT_THRU_FLAG && file_dest |=>
    file_wdata_q == {$past(borrow_inverse_flag_q), $past(file_rdata[7:1])} &&
    borrow_inverse_flag_q == $past(file_rdata[0]))
    else $error("rotate right into file wrong");

  chk_sub_file_wr: assert property (exec && op_code == FRA_OP_SUB_ACC_FROM_FILE && file_dest |=>
    file_wdata_q == 8'($past(file_rdata) - $past(acc_q)) && $stable(acc_q))
    else $error("subtract into file wrong");

  chk_sub_zero: assert property (exec && op_code == FRA_OP_SUB_ACC_FROM_FILE |=>
    zero_flag_q == ($past(file_rdata) == $past(acc_q)))
    else $error("subtract from file zero flag wrong");

  chk_sub_lit_flags: assert property (exec && op_code == FRA_OP_SUB_ACC_FROM_LITERAL |=>
    nibble_borrow_inverse_flag_q == ($past(acc_q[3:0]) <= $past(literal[3:0])) &&
    zero_flag_q == ($past(literal) == $past(acc_q)))
    else $error("subtract from literal flags wrong");

  chk_swap_acc: assert property (exec && op_code == FRA_OP_NIBBLE_EXCHANGE && !file_dest |=>
    acc_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("nibble exchange into accumulator wrong");

  chk_swap_file: assert property (exec && op_code == FRA_OP_NIBBLE_EXCHANGE && file_dest |=>
    file_wdata_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(acc_q))
    else $error("nibble exchange into file wrong");

  chk_xor_acc: assert property (exec && op_code == FRA_OP_XOR_ACC_WITH_FILE && !file_dest |=>
    acc_q == ($past(acc_q) ^ $past(file_rdata)) && $stable(borrow_inverse_flag_q))
    else $error("xor file into accumulator wrong");

  chk_zero_xor_file: assert property (exec && op_code == FRA_OP_XOR_ACC_WITH_FILE |=>
    zero_flag_q == (($past(acc_q) ^ $past(file_rdata)) == FRA_ZERO_BYTE))
    else $error("zero flag after xor file wrong");

  chk_sleep_osc: assert property (exec && op_code == FRA_OP_SLEEP |=>
    osc_halt_q && state_q == FRA_ST_SLEEP)
    else $error("oscillator not halted in sleep");

  chk_wake_resume: assert property (state_q == FRA_ST_SLEEP && wake_s |=>
    state_q == FRA_ST_RUN && !osc_halt_q)
    else $error("core did not resume after wake");

  cov_sleep_wake: cover property (exec && op_code == FRA_OP_SLEEP ##[1:50] state_q == FRA_ST_RUN);
  cov_sub_borrow: cover property (exec && op_code == FRA_OP_SUB_ACC_FROM_FILE && acc_q > file_rdata);
  cov_file_write: cover property (exec && file_dest ##1 file_we_q);
  cov_rotate_chain: cover property (exec && op_code == FRA_OP_ROTATE_RIGHT_THRU_FLAG ##1
    exec && op_code == FRA_OP_ROTATE_RIGHT_THRU_FLAG);
  cov_swap_file: cover property (exec && op_code == FRA_OP_NIBBLE_EXCHANGE && file_dest);

endmodule : fra_core
`default_nettype wire

/* File: design/fra_pkg.sv */
package fra_pkg;

  typedef enum logic [2:0] {
    FRA_OP_ROTATE_RIGHT_THRU_FLAG,
    FRA_OP_SUB_ACC_FROM_FILE,
    FRA_OP_SUB_ACC_FROM_LITERAL,
    FRA_OP_NIBBLE_EXCHANGE,
    FRA_OP_XOR_LITERAL_INTO_ACC,
    FRA_OP_XOR_ACC_WITH_FILE,
    FRA_OP_SLEEP
  } fra_op_t;

  typedef enum logic {
    FRA_ST_RUN,
    FRA_ST_SLEEP
  } fra_state_t;

  localparam int unsigned FRA_DATA_W   = 8;
  localparam int unsigned FRA_ADDR_W   = 7;
  localparam int unsigned FRA_PRE_W    = 7;
  localparam int unsigned FRA_NIB_MSB  = 3;
  localparam int unsigned FRA_NIB_W    = 4;
  localparam int unsigned FRA_MSB      = 7;

  localparam logic FRA_DEST_ACC        = 1'b0;
  localparam logic FRA_DEST_FILE       = 1'b1;

  localparam logic [7:0] FRA_ZERO_BYTE = 8'h00;
  localparam logic [6:0] FRA_PRE_RST   = 7'h00;
  localparam logic [6:0] FRA_PRE_ONE   = 7'h01;
  localparam logic [6:0] FRA_PRE_MAX   = 7'h7f;
  localparam logic [7:0] FRA_WDT_ONE   = 8'h01;
  localparam logic [6:0] FRA_ADDR_RST  = 7'h00;
  localparam logic       FRA_FLAG_CLR  = 1'b0;
  localparam logic       FRA_FLAG_SET  = 1'b1;
  localparam logic       FRA_TO_RST    = 1'b1;
  localparam logic       FRA_PD_RST    = 1'b1;

endpackage : fra_pkg

/* File: design/fra_alu_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fra_alu_if;
  import fra_pkg::*;
  fra_op_t     op;
  logic [7:0]  acc;
  logic [7:0]  fval;
  logic [7:0]  lit;
  logic        cin;
  logic [7:0]  result;
  logic        cout;
  logic        dcout;
  logic        zout;
  logic        wr_c;
  logic        wr_dc;
  logic        wr_z;
  logic        wr_result;

  modport core (output op, acc, fval, lit, cin,
                input  result, cout, dcout, zout, wr_c, wr_dc, wr_z, wr_result);
  modport alu  (input  op, acc, fval, lit, cin,
                output result, cout, dcout, zout, wr_c, wr_dc, wr_z, wr_result);
endinterface : fra_alu_if
`default_nettype wire

/* File: design/fra_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module fra_alu
  import fra_pkg::*;
(
  fra_alu_if.alu bus
);

  logic [8:0] diff_full;
  logic [4:0] diff_nib;
  logic [7:0] sub_src;

  always_comb begin
    sub_src       = (bus.op == FRA_OP_SUB_ACC_FROM_LITERAL) ? bus.lit : bus.fval;
    // Carry out of the 9-bit difference is the inverted borrow
    diff_full     = {1'b0, sub_src} - {1'b0, bus.acc};
    diff_nib      = {1'b0, sub_src[FRA_NIB_MSB:0]} - {1'b0, bus.acc[FRA_NIB_MSB:0]};
    bus.result    = FRA_ZERO_BYTE;
    bus.cout      = bus.cin;
    bus.dcout     = FRA_FLAG_CLR;
    bus.wr_c      = 1'b0;
    bus.wr_dc     = 1'b0;
    bus.wr_z      = 1'b0;
    bus.wr_result = 1'b1;
    unique case (bus.op)
      FRA_OP_ROTATE_RIGHT_THRU_FLAG: begin
        bus.result = {bus.cin, bus.fval[FRA_MSB:1]};
        bus.cout   = bus.fval[0];
        bus.wr_c   = 1'b1;
      end
      FRA_OP_SUB_ACC_FROM_FILE,
      FRA_OP_SUB_ACC_FROM_LITERAL: begin
        bus.result = diff_full[FRA_MSB:0];
        bus.cout   = ~diff_full[FRA_DATA_W];
        bus.dcout  = ~diff_nib[FRA_NIB_W];
        bus.wr_c   = 1'b1;
        bus.wr_dc  = 1'b1;
        bus.wr_z   = 1'b1;
      end
      FRA_OP_NIBBLE_EXCHANGE: begin
        bus.result = {bus.fval[FRA_NIB_MSB:0], bus.fval[FRA_MSB:FRA_NIB_W]};
      end
      FRA_OP_XOR_LITERAL_INTO_ACC: begin
        bus.result = bus.acc ^ bus.lit;
        bus.wr_z   = 1'b1;
      end
      FRA_OP_XOR_ACC_WITH_FILE: begin
        bus.result = bus.acc ^ bus.fval;
        bus.wr_z   = 1'b1;
      end
      FRA_OP_SLEEP: begin
        bus.wr_result = 1'b0;
      end
      default: begin
        bus.wr_result = 1'b0;
      end
    endcase
    bus.zout = (bus.result == FRA_ZERO_BYTE);
  end

endmodule : fra_alu
`default_nettype wire

/* File: bench/tb_file_register_alu_ops.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_file_register_alu_ops
  import fra_pkg::*;
;
  typedef struct packed {
    fra_op_t    op;
    logic [6:0] addr;
    logic       dest;
    logic [7:0] lit;
    logic [7:0] fdat;
    logic [7:0] acc;
    logic       we;
    logic [7:0] wdat;
    logic       c;
    logic       dc;
    logic       z;
  } fra_row_t;

  localparam fra_op_t op_rr = FRA_OP_ROTATE_RIGHT_THRU_FLAG;
  localparam fra_op_t op_sf = FRA_OP_SUB_ACC_FROM_FILE;
  localparam fra_op_t op_sl = FRA_OP_SUB_ACC_FROM_LITERAL;
  localparam fra_op_t op_sw = FRA_OP_NIBBLE_EXCHANGE;
  localparam fra_op_t op_xl = FRA_OP_XOR_LITERAL_INTO_ACC;
  localparam fra_op_t op_xf = FRA_OP_XOR_ACC_WITH_FILE;

  logic       clk;
  logic       reset_n;
  logic       op_valid;
  fra_op_t    op_code;
  logic [6:0] file_addr;
  logic       dest_sel;
  logic [7:0] literal;
  logic [7:0] file_rdata;
  logic       wake;
  logic       watchdog_tick;
  logic [7:0] acc;
  logic       we;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic       c_fl;
  logic       dc_fl;
  logic       z_fl;
  logic       to_fl;
  logic       pd_fl;
  logic [7:0] wdt;
  logic       halt;
  int         err_total;
  int         samples_checked;
  int         n;
  fra_row_t   rows [18];

  fra_core fra_core_i (
    .clk                          (clk),
    .reset_n                      (reset_n),
    .op_valid                     (op_valid),
    .op_code                      (op_code),
    .file_addr                    (file_addr),
    .dest_sel                     (dest_sel),
    .literal                      (literal),
    .file_rdata                   (file_rdata),
    .wake                         (wake),
    .watchdog_tick                (watchdog_tick),
    .acc_q                        (acc),
    .file_we_q                    (we),
    .file_waddr_q                 (waddr),
    .file_wdata_q                 (wdata),
    .borrow_inverse_flag_q        (c_fl),
    .nibble_borrow_inverse_flag_q (dc_fl),
    .zero_flag_q                  (z_fl),
    .timeout_flag_q               (to_fl),
    .power_down_flag_q            (pd_fl),
    .watchdog_counter_q           (wdt),
    .osc_halt_q                   (halt)
  );

  always #12.5 clk = ~clk;

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask : cmp_bit

  task automatic chk_status(input logic [7:0] a, input logic t, input logic p, input logic h);
    cmp_byte(acc, a);
    cmp_bit(to_fl, t);
    cmp_bit(pd_fl, p);
    cmp_bit(halt, h);
  endtask : chk_status

  task automatic drive(input fra_op_t o, input logic [6:0] a, input logic d, input logic [7:0] l,
                       input logic [7:0] f);
    op_valid   = 1'b1;
    op_code    = o;
    file_addr  = a;
    dest_sel   = d;
    literal    = l;
    file_rdata = f;
  endtask : drive

  // Tick held two cycles each phase so the two-flop sync sees every edge
  task automatic tick_n(input int cnt);
    repeat (cnt) begin
      watchdog_tick = 1'b1;
      repeat (2) @(negedge clk);
      watchdog_tick = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask : tick_n

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk             = 1'b0;
    reset_n         = 1'b0;
    op_valid        = 1'b0;
    op_code         = op_xl;
    file_addr       = 7'h00;
    dest_sel        = 1'b0;
    literal         = 8'h00;
    file_rdata      = 8'h00;
    wake            = 1'b0;
    watchdog_tick   = 1'b0;
    err_total       = 0;
    samples_checked = 0;
    // Rows run back to back; flags carry over from row to row
    rows = '{
      '{op_xl, 7'h00, 1'b1, 8'h5a, 8'h00, 8'h5a, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
      '{op_sl, 7'h00, 1'b0, 8'h5a, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1},
      '{op_xl, 7'h00, 1'b0, 8'h3c, 8'h00, 8'h3c, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0},
      '{op_sf, 7'h01, 1'b0, 8'h00, 8'h2b, 8'hef, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
      '{op_sf, 7'h7f, 1'b1, 8'h00, 8'h40, 8'hef, 1'b1, 8'h51, 1'b0, 1'b0, 1'b0},
      '{op_sf, 7'h00, 1'b1, 8'h00, 8'hef, 8'hef, 1'b1, 8'h00, 1'b1, 1'b1, 1'b1},
      '{op_rr, 7'h02, 1'b0, 8'h00, 8'h81, 8'hc0, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1},
      '{op_rr, 7'h12, 1'b1, 8'h00, 8'h02, 8'hc0, 1'b1, 8'h81, 1'b0, 1'b1, 1'b1},
      '{op_rr, 7'h03, 1'b0, 8'h00, 8'h01, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1},
      '{op_sw, 7'h04, 1'b0, 8'h00, 8'ha5, 8'h5a, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1},
      '{op_sw, 7'h33, 1'b1, 8'h00, 8'h0f, 8'h5a, 1'b1, 8'hf0, 1'b1, 1'b1, 1'b1},
      '{op_xf, 7'h05, 1'b0, 8'h00, 8'h5a, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1},
      '{op_xf, 7'h55, 1'b1, 8'h00, 8'hff, 8'h00, 1'b1, 8'hff, 1'b1, 1'b1, 1'b0},
      '{op_xl, 7'h00, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1},
      '{op_sl, 7'h00, 1'b0, 8'h10, 8'h00, 8'h10, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0},
      '{op_sl, 7'h00, 1'b0, 8'h0f, 8'h00, 8'hff, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0},
      '{op_sf, 7'h06, 1'b0, 8'h00, 8'h1e, 8'h1f, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
      '{op_sl, 7'h00, 1'b0, 8'h20, 8'h00, 8'h01, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0}
    };
    repeat (16) @(negedge clk);
    chk_status(8'h00, 1'b1, 1'b1, 1'b0);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      drive(rows[i].op, rows[i].addr, rows[i].dest, rows[i].lit, rows[i].fdat);
      @(negedge clk);
      cmp_byte(acc, rows[i].acc);
      cmp_bit(we, rows[i].we);
      if (rows[i].we) begin
        cmp_byte({1'b0, waddr}, {1'b0, rows[i].addr});
        cmp_byte(wdata, rows[i].wdat);
      end
      cmp_bit(c_fl, rows[i].c);
      cmp_bit(dc_fl, rows[i].dc);
      cmp_bit(z_fl, rows[i].z);
    end
    op_valid = 1'b0;
    // Prescaler wraps after 128 edges; two extra leave it mid-count
    tick_n(130);
    cmp_byte(wdt, 8'h01);
    drive(FRA_OP_SLEEP, 7'h00, 1'b0, 8'h00, 8'h00);
    @(negedge clk);
    drive(op_xf, 7'h09, 1'b1, 8'h00, 8'hff);
    cmp_byte(wdt, 8'h00);
    chk_status(8'h01, 1'b1, 1'b0, 1'b1);
    repeat (3) begin
      @(negedge clk);
      cmp_bit(we, 1'b0);
      chk_status(8'h01, 1'b1, 1'b0, 1'b1);
    end
    op_valid = 1'b0;
    tick_n(127);
    cmp_byte(wdt, 8'h00);
    tick_n(1);
    cmp_byte(wdt, 8'h01);
    wake = 1'b1;
    for (n = 0; n < 10 && halt !== 1'b0; n++) begin
      @(negedge clk);
    end
    cmp_bit(halt, 1'b0);
    if (halt !== 1'b0) begin
      end_of_test();
    end
    wake = 1'b0;
    drive(op_xl, 7'h00, 1'b0, 8'h01, 8'h00);
    @(negedge clk);
    op_valid = 1'b0;
    chk_status(8'h00, 1'b1, 1'b0, 1'b0);
    cmp_bit(z_fl, 1'b1);
    // Second reset in mid-run restores the status flags at once
    reset_n = 1'b0;
    #1;
    chk_status(8'h00, 1'b1, 1'b1, 1'b0);
    cmp_byte(wdt, 8'h00);
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    // First instruction is presented right at release
    drive(op_xl, 7'h00, 1'b0, 8'h3c, 8'h00);
    @(negedge clk);
    op_valid = 1'b0;
    chk_status(8'h3c, 1'b1, 1'b1, 1'b0);
    cmp_bit(z_fl, 1'b0);
    repeat (2) @(negedge clk);
    end_of_test();
  end
endmodule : tb_file_register_alu_ops
`default_nettype wire
